// [design/gpio_pin_output_mux.sv]
// output source and signal selection for general-purpose pin 7
//
// Function
// [RULE1] enable bit 0 turns the pin driver on
// [RULE2] source bits 4:2 pick rx, status or tx
// [RULE3] rx select 000-011 gives remote input 0-3
// [RULE4] rx select 100-111 gives lock, pass, fv, lv
// [RULE5] status select 000 gives output value bit
// [RULE6] status select 001 ORs enabled port locks
// [RULE7] status select 010/011 ANDs enabled port passes
// [RULE8] status select 100 gives frame sync
// [RULE9] tx select 000 ANDs, 001 ORs chosen passes
// [RULE10] tx select 010/011 give frame and line valid
// [RULE11] tx select 100 synced, 101 interrupt
// [RULE12] value bit 1 is the register-driven data
// [RULE13] reserved codes drive a constant low
// [RULE14] control register resets to all zero
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_output_mux
  import gpio_pin_output_mux_pkg::*;
#(
  parameter int ADDR_WIDTH = 10
) (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clkEn,
  input  wire logic [ADDR_WIDTH-1:0] address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  input  wire logic [3:0]            byteenable,
  output var  logic [31:0]           readdata,
  output var  logic                  waitrequest,
  input  wire rx_status_t            rxStatus [NUM_RX],
  input  wire tx_status_t            txStatus [NUM_TX],
  input  wire logic                  frameSyncSignal,
  output var  logic                  pinOut,
  output var  logic                  pinOutEnN
);

  //////////////////////////////////////////////////////////////////////////
  // register state

  pin_ctrl_t   ctrl_q;
  pin_ctrl_t   ctrl_d;
  port_cfg_t   cfg_q;
  port_cfg_t   cfg_d;
  logic        resp_q;
  logic [31:0] readdata_q;
  logic [31:0] readdata_d;

  //////////////////////////////////////////////////////////////////////////
  // bus decode

  wire logic [9:0] byteAddr;
  wire logic       request;
  wire logic       hitCtrl;
  wire logic       hitCfg;
  wire logic       hitStatus;
  wire logic       commit;
  wire logic       writeCtrl;
  wire logic       writeCfgLow;
  wire logic       writeCfgHigh;

  assign byteAddr = 10'(address);
  assign request  = read | write;
  assign hitCtrl   = byteAddr == CTRL_ADDR;
  assign hitCfg    = byteAddr == CFG_ADDR;
  assign hitStatus = byteAddr == STATUS_ADDR;

  // one wait cycle, then the request completes
  assign waitrequest = request & ~resp_q;
  assign commit      = write & resp_q & clkEn;

  assign writeCtrl    = commit & hitCtrl & byteenable[0];
  assign writeCfgLow  = commit & hitCfg & byteenable[0];
  assign writeCfgHigh = commit & hitCfg & byteenable[1];

  //////////////////////////////////////////////////////////////////////////
  // register next values

  wire logic [11:0] cfgBits;

  assign ctrl_d = writeCtrl ? pin_ctrl_t'(writedata[7:0]) : ctrl_q;

  assign cfgBits = {
    writeCfgHigh ? writedata[11:8] : cfg_q[11:8],
    writeCfgLow  ? writedata[7:0]  : cfg_q[7:0]
  };
  assign cfg_d = port_cfg_t'(cfgBits);

  //////////////////////////////////////////////////////////////////////////
  // port status flattened into vectors

  logic [3:0] rxLockVec;
  logic [3:0] rxPassVec;

  always_comb begin
    for (int i = 0; i < NUM_RX; i++) begin
      rxLockVec[i] = rxStatus[i].lock;
      rxPassVec[i] = rxStatus[i].pass;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // field decode

  wire logic [2:0] srcSel;
  wire logic [2:0] sigSel;
  wire logic       srcIsRx;
  wire logic       srcIsDevice;
  wire logic       srcIsTx;
  wire logic       srcReserved;
  wire logic [1:0] rxIdx;
  wire logic       txIdx;

  assign srcSel = ctrl_q.outputSourceSelect;
  assign sigSel = ctrl_q.outputSignalSelect;

  assign srcIsRx     = ~srcSel[2]; // RULE2
  assign srcIsDevice = srcSel == SRC_DEVICE; // RULE2
  assign srcIsTx     = srcSel[2] & srcSel[1]; // RULE2
  assign srcReserved = srcSel == SRC_RESERVED; // RULE13
  assign rxIdx       = srcSel[1:0]; // RULE2
  assign txIdx       = srcSel[0]; // RULE2

  //////////////////////////////////////////////////////////////////////////
  // receive port as source

  rx_status_t  rxSel;
  wire logic   rxRemote;
  wire logic   rxIndication;
  wire logic   rxValue;

  assign rxSel    = rxStatus[rxIdx];
  assign rxRemote = rxSel.remoteIn[sigSel[1:0]]; // RULE3

  assign rxIndication =
    (sigSel[1:0] == 2'h0) ? rxSel.lock :
    (sigSel[1:0] == 2'h1) ? rxSel.pass :
    (sigSel[1:0] == 2'h2) ? rxSel.frameValid :
                            rxSel.lineValid; // RULE4

  assign rxValue = sigSel[2] ? rxIndication : rxRemote; // RULE3 RULE4

  //////////////////////////////////////////////////////////////////////////
  // device status as source

  wire logic lockAny;
  wire logic passAll;
  wire logic devValue;

  assign lockAny = orMasked(rxLockVec, cfg_q.rxEnable); // RULE6
  assign passAll = andMasked(rxPassVec, cfg_q.rxEnable); // RULE7

  assign devValue =
    (sigSel == SEL_0) ? ctrl_q.outputValueBit : // RULE5 RULE12
    (sigSel == SEL_1) ? lockAny : // RULE6
    (sigSel == SEL_2) ? passAll : // RULE7
    (sigSel == SEL_3) ? passAll : // RULE7
    (sigSel == SEL_4) ? frameSyncSignal : // RULE8
                        1'b0; // RULE8 RULE13

  //////////////////////////////////////////////////////////////////////////
  // transmit port as source

  tx_status_t  txSel;
  wire logic [3:0] txMask;
  wire logic   txPassAnd;
  wire logic   txPassOr;
  wire logic   txValue;

  assign txSel  = txStatus[txIdx];
  assign txMask = txIdx ? cfg_q.tx1RxMask : cfg_q.tx0RxMask;

  assign txPassAnd = andMasked(rxPassVec, txMask); // RULE9
  assign txPassOr  = orMasked(rxPassVec, txMask); // RULE9

  assign txValue =
    (sigSel == SEL_0) ? txPassAnd : // RULE9
    (sigSel == SEL_1) ? txPassOr : // RULE9
    (sigSel == SEL_2) ? txSel.frameValid : // RULE10
    (sigSel == SEL_3) ? txSel.lineValid : // RULE10
    (sigSel == SEL_4) ? txSel.synced : // RULE11
    (sigSel == SEL_5) ? txSel.irq : // RULE11
                        1'b0; // RULE13

  //////////////////////////////////////////////////////////////////////////
  // final pin value and enable

  wire logic pinValue;
  wire logic pinDrive;

  assign pinValue =
    srcIsRx     ? rxValue :
    srcIsDevice ? devValue :
    srcIsTx     ? txValue :
                  1'b0; // RULE13

  assign pinDrive = ctrl_q.outputEnableBit; // RULE1

  pin_drive_stage u_drive (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .clkEn     (clkEn),
    .nextData  (pinValue & pinDrive), // RULE1
    .nextDrive (pinDrive), // RULE1
    .pinOut    (pinOut),
    .pinOutEnN (pinOutEnN)
  );

  //////////////////////////////////////////////////////////////////////////
  // read data

  wire logic [31:0] ctrlWord;
  wire logic [31:0] cfgWord;
  wire logic [31:0] statusWord;

  assign ctrlWord = {24'h000000, ctrl_q};
  assign cfgWord  = {20'h00000, cfg_q};
  assign statusWord = {
    26'h0000000,
    srcReserved,
    srcSel,
    ~pinOutEnN,
    pinOut
  };

  assign readdata_d =
    ~read         ? readdata_q :
    hitCtrl       ? ctrlWord :
    hitCfg        ? cfgWord :
    hitStatus     ? statusWord :
                    32'h00000000;

  assign readdata = readdata_q;

  //////////////////////////////////////////////////////////////////////////
  // flip-flops

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q <= pin_ctrl_t'(CTRL_RESET); // RULE14
      cfg_q  <= port_cfg_t'(CFG_RESET);
    end else if (clkEn) begin
      ctrl_q <= ctrl_d;
      cfg_q  <= cfg_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      resp_q     <= 1'b0;
      readdata_q <= 32'h00000000;
    end else if (clkEn) begin
      resp_q     <= request & ~resp_q;
      readdata_q <= (request & ~resp_q) ? readdata_d : readdata_q;
    end
  end

endmodule
`default_nettype wire

// [design/gpio_pin_output_mux_pkg.sv]
// constants, field layouts and helpers for the pin 7 output mux
package gpio_pin_output_mux_pkg;

  localparam int NUM_RX = 4;
  localparam int NUM_TX = 2;

  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_INDEX   = 8'h17;
  localparam logic [7:0] CFG_INDEX    = 8'h20;
  localparam logic [7:0] STATUS_INDEX = 8'h21;
  localparam logic [9:0] CTRL_ADDR    = {CTRL_INDEX, 2'b00};
  localparam logic [9:0] CFG_ADDR     = {CFG_INDEX, 2'b00};
  localparam logic [9:0] STATUS_ADDR  = {STATUS_INDEX, 2'b00};

  // control register fields
  localparam int EN_BIT     = 0;
  localparam int VAL_BIT    = 1;
  localparam int SRC_LSB    = 2;
  localparam int SEL_LSB    = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // port configuration register
  localparam logic [11:0] CFG_RESET = 12'hfff;
  localparam int CFG_WIDTH = 12;

  // source codes
  localparam logic [2:0] SRC_DEVICE   = 3'h4;
  localparam logic [2:0] SRC_RESERVED = 3'h5;

  // select codes
  localparam logic [2:0] SEL_0 = 3'h0;
  localparam logic [2:0] SEL_1 = 3'h1;
  localparam logic [2:0] SEL_2 = 3'h2;
  localparam logic [2:0] SEL_3 = 3'h3;
  localparam logic [2:0] SEL_4 = 3'h4;
  localparam logic [2:0] SEL_5 = 3'h5;

  typedef struct packed {
    logic [2:0] outputSignalSelect;
    logic [2:0] outputSourceSelect;
    logic       outputValueBit;
    logic       outputEnableBit;
  } pin_ctrl_t;

  typedef struct packed {
    logic [3:0] tx1RxMask;
    logic [3:0] tx0RxMask;
    logic [3:0] rxEnable;
  } port_cfg_t;

  typedef struct packed {
    logic [3:0] remoteIn;
    logic       lock;
    logic       pass;
    logic       frameValid;
    logic       lineValid;
  } rx_status_t;

  typedef struct packed {
    logic frameValid;
    logic lineValid;
    logic synced;
    logic irq;
  } tx_status_t;

  // AND over the ports in mask; empty mask gives 1
  function automatic logic andMasked(input logic [3:0] vals, input logic [3:0] mask);
    andMasked = &(vals | ~mask);
  endfunction

  // OR over the ports in mask; empty mask gives 0
  function automatic logic orMasked(input logic [3:0] vals, input logic [3:0] mask);
    orMasked = |(vals & mask);
  endfunction

endpackage

// [design/pin_drive_stage.sv]
// registered pin driver with active-low output enable
`timescale 1ns/1ps
`default_nettype none
module pin_drive_stage (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic clkEn,
  input  wire logic nextData,
  input  wire logic nextDrive,
  output var  logic pinOut,
  output var  logic pinOutEnN
);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pinOut    <= 1'b0;
      pinOutEnN <= 1'b1;
    end else if (clkEn) begin
      pinOut    <= nextData;
      pinOutEnN <= ~nextDrive;
    end
  end

endmodule
`default_nettype wire

// [tb/gpio_pin_output_mux_asserts.sv]
// assertions on pin 7 output selection
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_output_mux_asserts
  import gpio_pin_output_mux_pkg::*;
#(
  parameter int ADDR_WIDTH = 10
) (
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  input wire logic                  clkEn,
  input wire logic [ADDR_WIDTH-1:0] address,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic [31:0]           writedata,
  input wire logic [3:0]            byteenable,
  input wire logic                  waitrequest,
  input wire rx_status_t            rxStatus [NUM_RX],
  input wire tx_status_t            txStatus [NUM_TX],
  input wire logic                  frameSyncSignal,
  input wire logic                  pinOut,
  input wire logic                  pinOutEnN
);
  pin_ctrl_t  ctrlQ;
  logic [2:0] src;
  logic [2:0] sel;
  logic       on;
  assign src = ctrlQ.outputSourceSelect;
  assign sel = ctrlQ.outputSignalSelect;
  assign on = clkEn && ctrlQ.outputEnableBit;
  // shadow of the control register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrlQ <= '0;
    end else if (clkEn && write && !waitrequest && address == CTRL_ADDR && byteenable[0]) begin
      ctrlQ <= writedata[7:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  one_wait_a: assert property (clkEn && (read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  drive_enable_a: assert property (clkEn |=> pinOutEnN != $past(ctrlQ.outputEnableBit))
    else $error("pin enable wrong");
  off_low_a: assert property (pinOutEnN |-> !pinOut)
    else $error("undriven pin not low");
  rx_remote_a: assert property (on && !src[2] && !sel[2] |=>
    pinOut == $past(rxStatus[src[1:0]].remoteIn[sel[1:0]])) else $error("remote input wrong");
  rx_lock_a: assert property (on && !src[2] && sel == SEL_4 |=>
    pinOut == $past(rxStatus[src[1:0]].lock)) else $error("lock wrong");
  value_bit_a: assert property (on && src == SRC_DEVICE && sel == SEL_0 |=>
    pinOut == $past(ctrlQ.outputValueBit)) else $error("value bit wrong");
  frame_sync_a: assert property (on && src == SRC_DEVICE && sel == SEL_4 |=>
    pinOut == $past(frameSyncSignal)) else $error("frame sync wrong");
  reserved_low_a: assert property (on && src == SRC_RESERVED |=> !pinOut)
    else $error("reserved source not low");
  tx_irq_a: assert property (on && src[2:1] == 2'b11 && sel == SEL_5 |=>
    pinOut == $past(txStatus[src[0]].irq)) else $error("tx interrupt wrong");
  cover property (on && src == SRC_DEVICE);
  cover property (on && src[2:1] == 2'b11);
  cover property (write && !waitrequest);
endmodule
bind gpio_pin_output_mux gpio_pin_output_mux_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) asserts_i (
  .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
  .rxStatus(rxStatus), .txStatus(txStatus), .frameSyncSignal(frameSyncSignal),
  .pinOut(pinOut), .pinOutEnN(pinOutEnN));
`default_nettype wire

// [tb/pin_observer.sv]
// far-side logic watching pin 7
`timescale 1ns/1ps
`default_nettype none
module pin_observer (
  input  wire logic core_clk,
  input  wire logic pinOut,
  input  wire logic pinOutEnN,
  output var  logic pinLevel
);
  logic lastQ = 1'b0;
  always_ff @(posedge core_clk) begin
    lastQ <= pinLevel;
  end
  // undriven pin floats: show inverse of last level
  assign pinLevel = pinOutEnN ? ~lastQ : pinOut;
endmodule
`default_nettype wire

// [tb/gpio_pin_output_mux_bench.sv]
// self-checking bench for the pin 7 output selection
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_output_mux_bench;
  import gpio_pin_output_mux_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clkEn = 1'b1;
  logic [9:0]  address = '0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = '0;
  logic        frameSyncSignal = 1'b1;
  logic [31:0] readdata;
  logic [31:0] rdVal;
  logic        waitrequest;
  logic        pinOut;
  logic        pinOutEnN;
  logic        pinLevel;
  rx_status_t  rxStatus [NUM_RX] = '{8'h5a, 8'ha5, 8'h3c, 8'hc7};
  tx_status_t  txStatus [NUM_TX] = '{4'ha, 4'h5};
  int          numErrors = 0;
  int          nTests = 0;
  int          cycles = 0;
  // {expected pin, control byte}
  logic [8:0]  rows [30] = '{9'h101, 9'h125, 9'h049, 9'h16d, 9'h181, 9'h1a5, 9'h0c9, 9'h1ed,
    9'h113, 9'h011, 9'h131, 9'h051, 9'h071, 9'h191, 9'h0b1, 9'h0f1, 9'h015, 9'h019, 9'h139,
    9'h159, 9'h079, 9'h199, 9'h0b9, 9'h05d, 9'h17d, 9'h09d, 9'h1bd, 9'h0dd, 9'h0fd, 9'h012};
  gpio_pin_output_mux gpio_pin_output_mux_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .clkEn(clkEn), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest), .rxStatus(rxStatus),
    .txStatus(txStatus), .frameSyncSignal(frameSyncSignal), .pinOut(pinOut),
    .pinOutEnN(pinOutEnN));
  pin_observer pin_observer_i (.core_clk(core_clk), .pinOut(pinOut), .pinOutEnN(pinOutEnN),
    .pinLevel(pinLevel));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic busCycle(input logic isWr, input logic [9:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    address <= addr;
    writedata <= data;
    write <= isWr;
    read <= !isWr;
    do @(posedge core_clk); while (waitrequest);
    rdVal = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic checkBit(input string what, input logic expV, input logic seenV);
    nTests++;
    if (seenV !== expV) begin
      numErrors++;
      $display("wrong value %s expected %b seen %b", what, expV, seenV);
    end
  endtask
  task automatic checkWord(input string what, input logic [31:0] expV, input logic [31:0] seenV);
    nTests++;
    if (seenV !== expV) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", what, expV, seenV);
    end
  endtask
  // pin moves one edge after the control update
  task automatic pinCheck(input logic expPin, input logic expEnN);
    @(posedge core_clk);
    @(negedge core_clk);
    checkBit("pin enable", expEnN, pinOutEnN);
    checkBit("pin level", expPin, expEnN ? pinOut : pinLevel);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      numErrors++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    busCycle(1'b0, CTRL_ADDR, '0);
    checkWord("ctrl reset", {24'h0, CTRL_RESET}, rdVal);
    checkBit("reset enable", 1'b1, pinOutEnN);
    $display("test reset done");
    foreach (rows[i]) begin
      busCycle(1'b1, CTRL_ADDR, {24'h0, rows[i][7:0]});
      pinCheck(rows[i][8], !rows[i][0]);
    end
    $display("test table done");
    busCycle(1'b0, CTRL_ADDR, '0);
    checkWord("ctrl readback", 32'h12, rdVal);
    busCycle(1'b0, 10'h3fc, '0);
    checkWord("unmapped read", '0, rdVal);
    busCycle(1'b1, CFG_ADDR, 32'hffe);
    busCycle(1'b1, CTRL_ADDR, 32'h51);
    pinCheck(1'b1, 1'b0);
    busCycle(1'b1, CFG_ADDR, 32'h01e);
    busCycle(1'b1, CTRL_ADDR, 32'h39);
    pinCheck(1'b0, 1'b0);
    busCycle(1'b1, CTRL_ADDR, 32'h1d);
    pinCheck(1'b1, 1'b0);
    busCycle(1'b1, CTRL_ADDR, 32'h91);
    @(posedge core_clk);
    frameSyncSignal <= 1'b0;
    pinCheck(1'b0, 1'b0);
    $display("test masks done");
    print_verdict();
  end
endmodule
`default_nettype wire
